// ==== hw/tw_defs.svh ====
`ifndef TW_DEFS_SVH
`define TW_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define TW_CLK_NS 5
`define TW_STD_KBPS 100
`define TW_FAST_KBPS 400
`define TW_STD_QTR (1000000 / (`TW_STD_KBPS * 4 * `TW_CLK_NS))
`define TW_FAST_QTR (1000000 / (`TW_FAST_KBPS * 4 * `TW_CLK_NS))
`define TW_QTR_W 10

// ****************************************
// Frame fields
// ****************************************
`define TW_DIR_WRITE 1'h0
`define TW_DIR_READ 1'h1
`define TW_LAST_BIT 3'h7
`define TW_LAST_PHASE 2'h3
`define TW_SAMPLE_PHASE 2'h2

`endif

// ==== hw/tw_pkg.sv ====
package tw_pkg;

	typedef enum logic [1:0] {
		TW_OP_START = 2'b00,
		TW_OP_STOP = 2'b01,
		TW_OP_WRITE = 2'b10,
		TW_OP_READ = 2'b11
	} tw_op_type;

	typedef enum logic [3:0] {
		TW_ST_IDLE = 4'b0000,
		TW_ST_START = 4'b0001,
		TW_ST_RESTART = 4'b0010,
		TW_ST_TXBIT = 4'b0011,
		TW_ST_TXACK = 4'b0100,
		TW_ST_LOAD = 4'b0101,
		TW_ST_RXBIT = 4'b0110,
		TW_ST_RXACK = 4'b0111,
		TW_ST_STOP = 4'b1000
	} tw_state_type;

	typedef enum logic [1:0] {
		TW_PART_DEVW = 2'b00,
		TW_PART_ADDR = 2'b01,
		TW_PART_DATA = 2'b10,
		TW_PART_DEVR = 2'b11
	} tw_part_type;

endpackage

// ==== hw/tw_bit_if.sv ====
`timescale 1ns/1ps

interface tw_bit_if;
	import tw_pkg::*;
	logic req;
	tw_op_type op;
	logic wbit;
	logic fast;
	logic ready;
	logic done;
	logic rbit;

	modport ctl (output req, output op, output wbit, output fast,
		input ready, input done, input rbit);
	modport eng (input req, input op, input wbit, input fast,
		output ready, output done, output rbit);
endinterface

// ==== hw/tw_bitgen.sv ====
`timescale 1ns/1ps
`include "tw_defs.svh"

module tw_bitgen #(
	parameter logic [`TW_QTR_W-1:0] STD_QTR = `TW_QTR_W'(`TW_STD_QTR),
	parameter logic [`TW_QTR_W-1:0] FAST_QTR = `TW_QTR_W'(`TW_FAST_QTR)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control side
	tw_bit_if.eng bus,
	// Pins
	input wire logic sda_in,
	output logic scl,
	output logic sda_oe
);
	import tw_pkg::*;

	logic [2:0] sync, next_sync;
	logic sda_f, next_sda_f;
	logic busy, next_busy;
	tw_op_type op, next_op;
	logic wbit, next_wbit;
	logic [1:0] ph, next_ph;
	logic [`TW_QTR_W-1:0] cnt, next_cnt, limit;
	logic next_scl, next_sda_oe;
	logic rbit, next_rbit;
	logic done, next_done;

	assign bus.ready = ~busy;
	assign bus.done = done;
	assign bus.rbit = rbit;

	// ****************************************
	// Phase sequencer
	// ****************************************
	always_comb begin
		next_sync = {sync[1:0], sda_in};
		next_sda_f = (sync[1] == sync[2]) ? sync[2] : sda_f;
		next_busy = busy;
		next_op = op;
		next_wbit = wbit;
		next_ph = ph;
		next_cnt = cnt;
		next_rbit = rbit;
		next_done = 1'b0;
		limit = (bus.fast ? FAST_QTR : STD_QTR) - `TW_QTR_W'(1);
		if (!busy) begin
			if (bus.req) begin
				next_busy = 1'b1;
				next_op = bus.op;
				next_wbit = bus.wbit;
				next_ph = 2'h0;
				next_cnt = '0;
			end
		end else if (cnt == limit) begin
			next_cnt = '0;
			next_ph = ph + 2'h1;
			if (ph == `TW_SAMPLE_PHASE)
				next_rbit = sda_f;
			if (ph == `TW_LAST_PHASE) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end else begin
			next_cnt = cnt + `TW_QTR_W'(1);
		end
		// Pin levels per operation and phase
		next_scl = scl;
		next_sda_oe = sda_oe;
		if (next_busy) begin
			case (next_op)
			TW_OP_START: begin
				next_scl = (next_ph == 2'h0) ? scl : (next_ph != 2'h3);
				next_sda_oe = next_ph[1];
			end
			TW_OP_STOP: begin
				next_scl = (next_ph != 2'h0);
				next_sda_oe = ~next_ph[1];
			end
			TW_OP_WRITE: begin
				next_scl = (next_ph == 2'h1) || (next_ph == 2'h2);
				next_sda_oe = ~next_wbit;
			end
			default: begin
				next_scl = (next_ph == 2'h1) || (next_ph == 2'h2);
				next_sda_oe = 1'b0;
			end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync <= 3'h7;
			sda_f <= 1'b1;
			busy <= 1'b0;
			op <= TW_OP_STOP;
			wbit <= 1'b1;
			ph <= 2'h0;
			cnt <= '0;
			scl <= 1'b1;
			sda_oe <= 1'b0;
			rbit <= 1'b1;
			done <= 1'b0;
		end else begin
			sync <= next_sync;
			sda_f <= next_sda_f;
			busy <= next_busy;
			op <= next_op;
			wbit <= next_wbit;
			ph <= next_ph;
			cnt <= next_cnt;
			scl <= next_scl;
			sda_oe <= next_sda_oe;
			rbit <= next_rbit;
			done <= next_done;
		end
	end

endmodule

// ==== hw/tw_master.sv ====
`timescale 1ns/1ps
`include "tw_defs.svh"

// Operation
// - The block is sole master, drives SCL always and ignores arbitration and stretching.
// - SCL runs at a standard or a fast rate chosen per transfer.
// - SDA is only pulled low or released, never driven high.
// - Every address and data byte goes as eight bits, most significant first.
// - The receiver of each byte answers with an acknowledge in the ninth clock.
// - SDA changes only while SCL is low, except for start and stop.
// - Each transfer opens with a start and closes with a stop.
// - When receiving, the block pulls SDA low for the whole acknowledge clock of every byte but the last.
// - A released SDA in the acknowledge clock means not-acknowledge.
// - A write sends start, address with write bit, memory address, data, then stop.
// - The number of memory address bytes is selectable.
// - A read writes the memory address, then restarts with the read bit set.
// - The last byte read is answered with not-acknowledge and then stop.
// - Every byte read but the last is acknowledged.
module tw_master #(
	parameter logic [`TW_QTR_W-1:0] STD_QTR = `TW_QTR_W'(`TW_STD_QTR),
	parameter logic [`TW_QTR_W-1:0] FAST_QTR = `TW_QTR_W'(`TW_FAST_QTR)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command
	input wire logic start,
	input wire logic rd,
	input wire logic fast,
	input wire logic [6:0] dev_addr,
	input wire logic [1:0] addr_len,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] len_m1,
	// Write data
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_taken,
	// Read data
	output logic [7:0] rx_data,
	output logic rx_valid,
	// Status
	output logic busy,
	output logic done,
	output logic nack_err,
	// Bus pins
	output logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	import tw_pkg::*;

	tw_bit_if bit_bus ();

	tw_state_type state, next_state;
	tw_part_type part, next_part;
	logic [7:0] shift, next_shift;
	logic [2:0] bitn, next_bitn;
	logic [1:0] alen, next_alen;
	logic [15:0] maddr, next_maddr;
	logic [7:0] remain, next_remain;
	logic rd_r, next_rd_r;
	logic [6:0] dev, next_dev;
	logic fast_r, next_fast_r;
	logic pend, next_pend;
	logic next_busy, next_done, next_nack_err;
	logic next_tx_taken, next_rx_valid;
	logic [7:0] next_rx_data;
	logic [7:0] addr_byte;

	// ****************************************
	// Bit engine
	// ****************************************
	tw_bitgen #(
		.STD_QTR(STD_QTR),
		.FAST_QTR(FAST_QTR)
	) u_bitgen (
		.clk(clk),
		.rst(rst),
		.bus(bit_bus.eng),
		.sda_in(sda_in),
		.scl(scl),
		.sda_oe(sda_oe)
	);

	// Open drain: the pin level when enabled is always low
	assign sda_out = 1'b0;

	assign addr_byte = (alen == 2'h2) ? maddr[15:8] : maddr[7:0];

	// ****************************************
	// Bit requests
	// ****************************************
	always_comb begin
		bit_bus.fast = fast_r;
		bit_bus.req = 1'b0;
		bit_bus.op = TW_OP_STOP;
		bit_bus.wbit = 1'b1;
		if (!pend && bit_bus.ready) begin
			case (state)
			TW_ST_START, TW_ST_RESTART: begin
				bit_bus.req = 1'b1;
				bit_bus.op = TW_OP_START;
			end
			TW_ST_TXBIT: begin
				bit_bus.req = 1'b1;
				bit_bus.op = TW_OP_WRITE;
				bit_bus.wbit = shift[7];
			end
			TW_ST_TXACK, TW_ST_RXBIT: begin
				bit_bus.req = 1'b1;
				bit_bus.op = TW_OP_READ;
			end
			TW_ST_RXACK: begin
				bit_bus.req = 1'b1;
				bit_bus.op = TW_OP_WRITE;
				// Low acknowledge unless last byte
				bit_bus.wbit = (remain == 8'h00);
			end
			TW_ST_STOP: begin
				bit_bus.req = 1'b1;
				bit_bus.op = TW_OP_STOP;
			end
			default: begin
				bit_bus.req = 1'b0;
			end
			endcase
		end
	end

	// ****************************************
	// Transfer sequencer
	// ****************************************
	always_comb begin
		next_state = state;
		next_part = part;
		next_shift = shift;
		next_bitn = bitn;
		next_alen = alen;
		next_maddr = maddr;
		next_remain = remain;
		next_rd_r = rd_r;
		next_dev = dev;
		next_fast_r = fast_r;
		next_busy = busy;
		next_done = 1'b0;
		next_nack_err = nack_err;
		next_tx_taken = 1'b0;
		next_rx_valid = 1'b0;
		next_rx_data = rx_data;
		next_pend = pend;
		if (bit_bus.req)
			next_pend = 1'b1;
		if (bit_bus.done)
			next_pend = 1'b0;
		case (state)
		TW_ST_IDLE: begin
			if (start) begin
				next_state = TW_ST_START;
				next_busy = 1'b1;
				next_nack_err = 1'b0;
				next_rd_r = rd;
				next_dev = dev_addr;
				next_fast_r = fast;
				next_alen = addr_len;
				next_maddr = mem_addr;
				next_remain = len_m1;
			end
		end
		TW_ST_START: begin
			if (bit_bus.done) begin
				next_shift = {dev, `TW_DIR_WRITE};
				next_part = TW_PART_DEVW;
				next_bitn = 3'h0;
				next_state = TW_ST_TXBIT;
			end
		end
		TW_ST_RESTART: begin
			if (bit_bus.done) begin
				next_shift = {dev, `TW_DIR_READ};
				next_part = TW_PART_DEVR;
				next_bitn = 3'h0;
				next_state = TW_ST_TXBIT;
			end
		end
		TW_ST_TXBIT: begin
			if (bit_bus.done) begin
				next_shift = {shift[6:0], 1'b0};
				next_bitn = bitn + 3'h1;
				if (bitn == `TW_LAST_BIT)
					next_state = TW_ST_TXACK;
			end
		end
		TW_ST_TXACK: begin
			if (bit_bus.done) begin
				next_bitn = 3'h0;
				if (bit_bus.rbit) begin
					// Slave refused the byte
					next_nack_err = 1'b1;
					next_state = TW_ST_STOP;
				end else begin
					case (part)
					TW_PART_DEVW: begin
						if (alen != 2'h0) begin
							next_part = TW_PART_ADDR;
							next_shift = addr_byte;
							next_state = TW_ST_TXBIT;
						end else if (rd_r) begin
							next_state = TW_ST_RESTART;
						end else begin
							next_state = TW_ST_LOAD;
						end
					end
					TW_PART_ADDR: begin
						next_alen = alen - 2'h1;
						if (alen == 2'h1) begin
							next_state = rd_r ? TW_ST_RESTART : TW_ST_LOAD;
						end else begin
							next_shift = maddr[7:0];
							next_state = TW_ST_TXBIT;
						end
					end
					TW_PART_DATA: begin
						if (remain == 8'h00) begin
							next_state = TW_ST_STOP;
						end else begin
							next_remain = remain - 8'h01;
							next_state = TW_ST_LOAD;
						end
					end
					default: begin
						next_state = TW_ST_RXBIT;
					end
					endcase
				end
			end
		end
		TW_ST_LOAD: begin
			// SCL rests low while the source has no byte
			if (tx_valid) begin
				next_shift = tx_data;
				next_tx_taken = 1'b1;
				next_part = TW_PART_DATA;
				next_bitn = 3'h0;
				next_state = TW_ST_TXBIT;
			end
		end
		TW_ST_RXBIT: begin
			if (bit_bus.done) begin
				next_shift = {shift[6:0], bit_bus.rbit};
				next_bitn = bitn + 3'h1;
				if (bitn == `TW_LAST_BIT)
					next_state = TW_ST_RXACK;
			end
		end
		TW_ST_RXACK: begin
			if (bit_bus.done) begin
				next_rx_data = shift;
				next_rx_valid = 1'b1;
				next_bitn = 3'h0;
				if (remain == 8'h00) begin
					next_state = TW_ST_STOP;
				end else begin
					next_remain = remain - 8'h01;
					next_state = TW_ST_RXBIT;
				end
			end
		end
		TW_ST_STOP: begin
			if (bit_bus.done) begin
				next_state = TW_ST_IDLE;
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
		default: begin
			next_state = TW_ST_IDLE;
			next_busy = 1'b0;
		end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= TW_ST_IDLE;
			part <= TW_PART_DEVW;
			shift <= 8'h00;
			bitn <= 3'h0;
			alen <= 2'h0;
			maddr <= 16'h0000;
			remain <= 8'h00;
			rd_r <= 1'b0;
			dev <= 7'h00;
			fast_r <= 1'b0;
			pend <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			nack_err <= 1'b0;
			tx_taken <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
		end else begin
			state <= next_state;
			part <= next_part;
			shift <= next_shift;
			bitn <= next_bitn;
			alen <= next_alen;
			maddr <= next_maddr;
			remain <= next_remain;
			rd_r <= next_rd_r;
			dev <= next_dev;
			fast_r <= next_fast_r;
			pend <= next_pend;
			busy <= next_busy;
			done <= next_done;
			nack_err <= next_nack_err;
			tx_taken <= next_tx_taken;
			rx_valid <= next_rx_valid;
			rx_data <= next_rx_data;
		end
	end

endmodule

// ==== bench/tw_chk.sv ====
`timescale 1ns/1ps
`include "tw_defs.svh"
// ********
// Checker
// ********
module tw_chk #(
	parameter logic [`TW_QTR_W-1:0] STD_QTR = `TW_QTR_W'(`TW_STD_QTR),
	parameter logic [`TW_QTR_W-1:0] FAST_QTR = `TW_QTR_W'(`TW_FAST_QTR)
) (
	// Clock and command
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic fast,
	// Status and pins
	input wire logic busy,
	input wire logic done,
	input wire logic nack_err,
	input wire logic scl,
	input wire logic sda_out,
	input wire logic sda_oe
);
	localparam int OPEN_MAX = 3 * STD_QTR + 16;
	logic [11:0] hi_cnt, next_hi_cnt, q_sel, next_q_sel;
	logic was_low, next_was_low;
	always_comb begin
		next_hi_cnt = scl ? hi_cnt + 12'h1 : 12'h0;
		next_q_sel = (start && !busy) ? (fast ? 12'(FAST_QTR) : 12'(STD_QTR)) : q_sel;
		next_was_low = busy && (was_low || !scl);
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hi_cnt <= 12'h0;
			q_sel <= 12'h0;
			was_low <= 1'h0;
		end else begin
			hi_cnt <= next_hi_cnt;
			q_sel <= next_q_sel;
			was_low <= next_was_low;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_launch;
		start && !busy ##1 busy;
	endsequence
	sequence s_open;
		scl && $rose(sda_oe);
	endsequence
	a_start_open: assert property (s_launch |-> ##[1:OPEN_MAX] s_open)
		else $error("start missing");
	a_start_hold: assert property (s_launch |=> scl until sda_oe)
		else $error("scl fell early");
	a_scl_width: assert property ($fell(scl) && was_low |->
		hi_cnt - (q_sel << 1) <= 12'h2) else $error("scl high time");
	a_sda_stable: assert property ($rose(scl) |=> $stable(sda_oe) [*3])
		else $error("sda moved");
	a_idle_lines: assert property (!busy |-> scl && !sda_oe)
		else $error("bus not idle");
	a_done_pulse: assert property (done |-> !busy ##1 !done)
		else $error("bad done");
	a_open_drain: assert property (sda_out == 1'h0)
		else $error("sda driven high");
	a_nack_clear: assert property (s_launch |-> !nack_err)
		else $error("flag kept");
endmodule

bind tw_master tw_chk #(.STD_QTR(STD_QTR), .FAST_QTR(FAST_QTR)) i_tw_chk (.clk(clk),
	.rst(rst), .start(start), .fast(fast), .busy(busy), .done(done), .nack_err(nack_err),
	.scl(scl), .sda_out(sda_out), .sda_oe(sda_oe));

// ==== bench/tw_slave.sv ====
`timescale 1ns/1ps
// ********
// Slave model
// ********
module tw_slave (
	// Bus
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	output logic pull,
	// Behaviour
	input wire logic [7:0] nack_at,
	input wire logic [7:0] rd_base
);
	logic [7:0] sh, rd_byte;
	logic rdm, first, nk;
	int bc, nb, nstart;
	logic [7:0] log_q[$];
	logic mack_q[$];
	initial pull = 1'b0;
	always @(posedge rst) begin
		pull = 1'b0;
		rdm = 1'b0;
		bc = -1;
	end
	always @(negedge sda) begin
		if (scl) begin
			bc = -1;
			first = 1'b1;
			rdm = 1'b0;
			nstart++;
		end
	end
	always @(posedge scl) begin
		if (bc >= 0 && bc < 8) sh = {sh[6:0], sda};
		if (bc == 8 && rdm) nk = sda;
		if (bc == 8 && rdm) mack_q.push_back(sda);
	end
	always @(negedge scl) begin
		bc++;
		if (bc == 8) begin
			pull = !rdm && nb != nack_at;
			if (!rdm) log_q.push_back(sh);
			if (!rdm) nb++;
		end
		if (bc == 9) begin
			bc = 0;
			pull = 1'b0;
			if (rdm && nk) rdm = 1'b0;
			if (rdm) rd_byte++;
			if (first && sh[0]) rd_byte = rd_base;
			if (first && sh[0]) rdm = 1'b1;
			first = 1'b0;
		end
		if (rdm && bc < 8) pull = !rd_byte[7 - bc];
	end
endmodule

// ==== bench/tw_master_test.sv ====
`timescale 1ns/1ps
// ********
// Testbench
// ********
module tw_master_test;
	typedef struct packed {
		logic rd;
		logic fast;
		logic [1:0] alen;
		logic [7:0] len;
		logic [7:0] nack;
	} tw_row_type;
	localparam logic [6:0] DEV = 7'h2b;
	logic clk = 1'b0, rst = 1'b1, start = 1'b0, rd = 1'b0, fast = 1'b0, tx_valid = 1'b1;
	logic [1:0] addr_len = 2'h0;
	logic [15:0] mem_addr = 16'h5c3a;
	logic [7:0] len_m1 = 8'h0, tx_data = 8'ha0, nack_at = 8'hff, rd_base = 8'h96;
	logic [7:0] rx_data;
	logic tx_taken, rx_valid, busy, done, nack_err, scl, sda_out, sda_oe, pull;
	wire sda = !(sda_oe || pull);
	int error_cnt = 0, n_checks = 0, cyc = 0, k = 0;
	logic [7:0] rxq[$];
	tw_row_type rows[6] = '{'{0, 0, 1, 0, 255}, '{0, 1, 2, 2, 255}, '{1, 0, 1, 0, 255},
		'{1, 1, 2, 2, 255}, '{1, 0, 0, 1, 255}, '{0, 1, 0, 0, 255}};
	always #2.5 clk = ~clk;
	tw_master #(.STD_QTR(10'h8), .FAST_QTR(10'h4)) i_tw_master (.clk(clk), .rst(rst),
		.start(start), .rd(rd), .fast(fast), .dev_addr(DEV), .addr_len(addr_len),
		.mem_addr(mem_addr), .len_m1(len_m1), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_taken(tx_taken), .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy),
		.done(done), .nack_err(nack_err), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe));
	tw_slave i_tw_slave (.rst(rst), .scl(scl), .sda(sda), .pull(pull), .nack_at(nack_at),
		.rd_base(rd_base));
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(negedge clk) begin
		cyc++;
		if (tx_taken === 1'b1) begin
			k++;
			tx_data <= 8'ha0 + 8'(k);
		end
		if (rx_valid === 1'b1) rxq.push_back(rx_data);
		if (cyc == 60000) begin
			error_cnt++;
			end_sim();
		end
	end
	task run(input tw_row_type r);
		int t;
		@(negedge clk);
		{rd, fast, addr_len, len_m1, nack_at} = r;
		k = 0;
		tx_data = 8'ha0;
		rxq.delete();
		i_tw_slave.log_q.delete();
		i_tw_slave.mack_q.delete();
		i_tw_slave.nstart = 0;
		i_tw_slave.nb = 0;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		t = 0;
		while (busy === 1'b1 && t < 20000) begin
			@(negedge clk);
			t++;
		end
	endtask
	function automatic logic [7:0] exp_byte(tw_row_type r, int i);
		if (i == 0) return {DEV, 1'b0};
		if (i == 1 && r.alen == 2'h2) return mem_addr[15:8];
		if (i <= int'(r.alen)) return mem_addr[7:0];
		if (r.rd) return {DEV, 1'b1};
		return 8'ha0 + 8'(i - 1 - int'(r.alen));
	endfunction
	task check_row(input tw_row_type r);
		chk("done", 1, done);
		chk("nack", 0, nack_err);
		chk("starts", r.rd ? 2 : 1, i_tw_slave.nstart);
		chk("bytes", r.rd ? 2 + r.alen : 2 + r.alen + r.len,
			i_tw_slave.log_q.size());
		foreach (i_tw_slave.log_q[i])
			chk("byte", exp_byte(r, i), i_tw_slave.log_q[i]);
		if (r.rd) begin
			chk("rx count", r.len + 1, rxq.size());
			foreach (rxq[i]) chk("rx", rd_base + 8'(i), rxq[i]);
			foreach (i_tw_slave.mack_q[i])
				chk("ack", i == r.len, i_tw_slave.mack_q[i]);
		end
	endtask
	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		chk("scl", 1, scl);
		chk("sda_oe", 0, sda_oe);
		$display("test reset done");
		foreach (rows[i]) begin
			run(rows[i]);
			check_row(rows[i]);
			$display("test %0d done", i);
		end
		run(tw_row_type'{0, 0, 1, 1, 0});
		chk("nack addr", 1, nack_err);
		chk("bytes", 1, i_tw_slave.log_q.size());
		run(tw_row_type'{0, 1, 1, 2, 3});
		chk("nack data", 1, nack_err);
		chk("bytes", 4, i_tw_slave.log_q.size());
		$display("test nack done");
		tx_valid = 1'b0;
		fork
			run(rows[0]);
			begin
				repeat (1000) @(negedge clk);
				chk("stall scl", 0, scl);
				chk("stall busy", 1, busy);
				tx_valid = 1'b1;
			end
		join
		check_row(rows[0]);
		$display("test stall done");
		fork
			run(rows[3]);
			begin
				repeat (300) @(negedge clk);
				rst = 1'b1;
				@(negedge clk);
				chk("reset scl", 1, scl);
				chk("reset sda", 0, sda_oe);
				rst = 1'b0;
			end
		join
		run(rows[2]);
		check_row(rows[2]);
		$display("test mid reset done");
		end_sim();
	end
endmodule
